// file: rtl/electronic_cam_controller.sv
// Purpose: Electronic cam controller with AXI4-Lite registers and interrupt
// Assumes: Position inputs come from logic on clk; one scan per processing tick
// Notes:   One cam is evaluated every two cycles after the tick
`include "cam_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module electronic_cam_controller #(
    parameter int NumCams    = `CAM_NUM_CAMS,
    parameter int TickCycles = `CAM_TICK_NS / `CAM_CLK_NS
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire cam_pkg::axi_req_t axiReq,
    output cam_pkg::axi_rsp_t      axiRsp,
    input  wire logic [31:0]       positionEncoderPos,
    input  wire logic [31:0]       referenceEncoderPos,
    input  wire logic [31:0]       actualPosition,
    output logic [15:0]            camSwitchFlag,
    output logic [255:0]           plcFlag,
    output logic [NumCams-1:0]     camActive,
    output logic                   irq
);

    typedef struct packed {
        logic                           awReady;
        logic                           awHeld;
        logic [11:0]                    awAddr;
        logic                           wReady;
        logic                           wHeld;
        logic [31:0]                    wData;
        logic [3:0]                     wStrb;
        logic                           bValid;
        logic [1:0]                     bResp;
        logic                           arReady;
        logic                           rPend;
        logic [11:0]                    arAddr;
        logic                           rValid;
        logic [31:0]                    rData;
        logic [1:0]                     rResp;
        logic [3:0]                     camCount;
        cam_pkg::pos_source_t           source;
        logic [31:0]                    cycleLen;
        logic [31:0]                    hyst;
        logic [NumCams-1:0]             irqStat;
        logic [NumCams-1:0]             irqEn;
        logic                           irq;
        logic [31:0]                    tickCnt;
        logic [31:0]                    lastSrc;
        logic [31:0]                    cycPos;
        cam_pkg::scan_state_t           scan;
        logic [3:0]                     idx;
        logic [3:0]                     scanCount;
        logic [31:0]                    scanPos;
        logic [NumCams-1:0]             active;
        logic [NumCams-1:0][31:0]       entryPos;
        logic [15:0]                    switchFlags;
        logic [255:0]                   plcFlags;
    } state_t;

    state_t              q;
    state_t              d;
    cam_pkg::mem_req_t   memReq;
    cam_pkg::cam_entry_t rdEntry;
    logic                tickHit;
    logic [31:0]         srcPos;
    logic [31:0]         cycAcc;
    logic                camInside;
    logic [31:0]         camDist;
    logic                evalEnter;
    logic                evalLeave;
    logic [15:0]         actSwitch;
    logic [7:0]          actFlagA;
    logic [7:0]          actFlagB;
    logic [31:0]         ctrlMerged;
    logic [31:0]         wMerged;

    // Byte-lane merge for register writes
    function automatic logic [31:0] strbMerge(input logic [31:0] oldV, input logic [31:0] newV,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = oldV;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b * 8 +: 8] = newV[b * 8 +: 8];
            end
        end
        return r;
    endfunction : strbMerge

    // Table storage, written by the bus, read by the scanner or the bus
    // one entry per cam
    cam_table_mem #(
        .Depth  (NumCams)
    ) u_table (
        .clk    (clk),
        .rst    (rst),
        .memReq (memReq),
        .rdEntry(rdEntry)
    );

    // Whole next-state computation
    always_comb begin
        d          = q;
        memReq     = '0;
        ctrlMerged = strbMerge({22'h0, q.source, 4'h0, q.camCount}, q.wData, q.wStrb);
        wMerged    = '0;
        tickHit    = (q.tickCnt == 32'(TickCycles - 1));
        actSwitch  = rdEntry.action[15:0];
        actFlagA   = rdEntry.action[`CAM_ACT_FLAGA_LSB +: 8];
        actFlagB   = rdEntry.action[`CAM_ACT_FLAGB_LSB +: 8];
        case (q.source)
            cam_pkg::SOURCE_POSITION_ENCODER:  srcPos = positionEncoderPos;
            cam_pkg::SOURCE_REFERENCE_ENCODER: srcPos = referenceEncoderPos;
            default:                           srcPos = actualPosition;
        endcase
        cycAcc    = q.cycPos + (srcPos - q.lastSrc);
        if (q.scan == cam_pkg::SCAN_EVAL) begin
            if (rdEntry.startPos <= rdEntry.endPos) begin
                camInside = (q.scanPos >= rdEntry.startPos) && (q.scanPos <= rdEntry.endPos);
            end else begin
                camInside = (q.scanPos >= rdEntry.startPos) || (q.scanPos <= rdEntry.endPos);
            end
        end else begin
            camInside = 1'b0;
        end
        camDist   = (q.scanPos >= q.entryPos[q.idx]) ? q.scanPos - q.entryPos[q.idx]
                                                     : q.entryPos[q.idx] - q.scanPos;
        evalEnter = (q.scan == cam_pkg::SCAN_EVAL) && camInside && !q.active[q.idx];
        evalLeave = (q.scan == cam_pkg::SCAN_EVAL) && !camInside && q.active[q.idx] && (camDist > q.hyst);

        // Write address and data channels, taken in either order
        if (axiReq.awvalid && q.awReady) begin
            d.awHeld  = 1'b1;
            d.awAddr  = axiReq.awaddr;
            d.awReady = 1'b0;
        end
        if (axiReq.wvalid && q.wReady) begin
            d.wHeld  = 1'b1;
            d.wData  = axiReq.wdata;
            d.wStrb  = axiReq.wstrb;
            d.wReady = 1'b0;
        end
        if (q.awHeld && q.wHeld && !q.bValid) begin
            d.awHeld = 1'b0;
            d.wHeld  = 1'b0;
            d.bValid = 1'b1;
            d.bResp  = `CAM_RESP_OKAY;
            if (q.awAddr[11:8] == `CAM_TABLE_PAGE) begin
                memReq.wrEn   = 1'b1;
                memReq.wrIdx  = q.awAddr[7:4];
                memReq.wrWord = q.awAddr[3:2];
                memReq.wrStrb = q.wStrb;
                memReq.wrData = (q.awAddr[3:2] == `CAM_WORD_ACTION) ? q.wData : q.wData & `CAM_POS_MASK;
            end else begin
                case (q.awAddr)
                    `CAM_OFF_CTRL: begin
                        d.camCount = ctrlMerged[`CAM_CTRL_COUNT_LSB +: 4];
                        if (ctrlMerged[`CAM_CTRL_SRC_LSB +: 2] != 2'h3) begin
                            d.source = cam_pkg::pos_source_t'(ctrlMerged[`CAM_CTRL_SRC_LSB +: 2]);
                        end
                    end
                    `CAM_OFF_CYCLE: begin
                        wMerged    = strbMerge(q.cycleLen, q.wData, q.wStrb);
                        d.cycleLen = wMerged & `CAM_POS_MASK;
                    end
                    `CAM_OFF_HYST: begin
                        wMerged = strbMerge(q.hyst, q.wData, q.wStrb);
                        d.hyst  = wMerged & `CAM_POS_MASK;
                    end
                    `CAM_OFF_IRQ_CLR: begin
                        wMerged   = strbMerge(32'h0, q.wData, q.wStrb);
                        d.irqStat = q.irqStat & ~wMerged[NumCams-1:0];
                    end
                    `CAM_OFF_IRQ_EN: begin
                        wMerged = strbMerge(32'(q.irqEn), q.wData, q.wStrb);
                        d.irqEn = wMerged[NumCams-1:0];
                    end
                    `CAM_OFF_ACTIVE, `CAM_OFF_SWITCH, `CAM_OFF_IRQ_STAT, `CAM_OFF_POS: d.bResp = `CAM_RESP_OKAY;
                    default: d.bResp = `CAM_RESP_SLVERR;
                endcase
            end
        end
        if (q.bValid && axiReq.bready) begin
            d.bValid  = 1'b0;
            d.awReady = 1'b1;
            d.wReady  = 1'b1;
        end

        // Read channel: table word comes from the memory one edge later
        memReq.rdIdx = (q.scan == cam_pkg::SCAN_READ) ? q.idx : axiReq.araddr[7:4];
        if (axiReq.arvalid && q.arReady) begin
            d.arAddr = axiReq.araddr;
            d.rPend  = 1'b1;
        end
        if (q.rPend) begin
            d.rPend  = 1'b0;
            d.rValid = 1'b1;
            d.rResp  = `CAM_RESP_OKAY;
            if (q.arAddr[11:8] == `CAM_TABLE_PAGE) begin
                case (q.arAddr[3:2])
                    `CAM_WORD_START:  d.rData = rdEntry.startPos;
                    `CAM_WORD_END:    d.rData = rdEntry.endPos;
                    `CAM_WORD_ACTION: d.rData = rdEntry.action;
                    default:          d.rData = 32'h0;
                endcase
            end else begin
                case (q.arAddr)
                    `CAM_OFF_CTRL:     d.rData = {22'h0, q.source, 4'h0, q.camCount};
                    `CAM_OFF_CYCLE:    d.rData = q.cycleLen;
                    `CAM_OFF_HYST:     d.rData = q.hyst;
                    `CAM_OFF_ACTIVE:   d.rData = 32'(q.active);
                    `CAM_OFF_SWITCH:   d.rData = {16'h0, q.switchFlags};
                    `CAM_OFF_IRQ_STAT: d.rData = 32'(q.irqStat);
                    `CAM_OFF_IRQ_CLR:  d.rData = 32'h0;
                    `CAM_OFF_IRQ_EN:   d.rData = 32'(q.irqEn);
                    `CAM_OFF_POS:      d.rData = q.cycPos;
                    default: begin
                        d.rData = 32'h0;
                        d.rResp = `CAM_RESP_SLVERR;
                    end
                endcase
            end
        end
        if (q.rValid && axiReq.rready) begin
            d.rValid = 1'b0;
        end

        // Processing tick and cycle position tracking
        d.tickCnt = tickHit ? 32'h0 : q.tickCnt + 32'h1;
        if (tickHit) begin
            d.lastSrc = srcPos;
            if (q.source == cam_pkg::SOURCE_ACTUAL_POSITION || q.cycleLen == 32'h0) begin
                // actual position supplies its own cycle
                d.cycPos = srcPos;
            end else if (cycAcc[31]) begin
                d.cycPos = cycAcc + q.cycleLen;
            end else if (cycAcc >= q.cycleLen) begin
                d.cycPos = cycAcc - q.cycleLen;
            end else begin
                d.cycPos = cycAcc;
            end
        end

        // Scanner: read one table entry, then evaluate it
        case (q.scan)
            cam_pkg::SCAN_IDLE: begin
                if (tickHit && q.camCount != 4'h0) begin
                    d.scan      = cam_pkg::SCAN_READ;
                    d.idx       = 4'h0;
                    d.scanCount = q.camCount;
                    d.scanPos   = d.cycPos;
                end
            end
            cam_pkg::SCAN_READ: d.scan = cam_pkg::SCAN_EVAL;
            cam_pkg::SCAN_EVAL: begin
                if (evalEnter) begin
                    d.active[q.idx]   = 1'b1;
                    d.entryPos[q.idx] = q.scanPos;
                    d.switchFlags     = q.switchFlags | actSwitch;
                    d.plcFlags[actFlagA] = 1'b1;
                    d.plcFlags[actFlagB] = 1'b1;
                    d.irqStat[q.idx]     = 1'b1;
                end
                if (evalLeave) begin
                    d.active[q.idx]      = 1'b0;
                    d.switchFlags        = q.switchFlags & ~actSwitch;
                    d.plcFlags[actFlagA] = 1'b0;
                    d.plcFlags[actFlagB] = 1'b0;
                end
                if (q.idx == q.scanCount - 4'h1) begin
                    d.scan = cam_pkg::SCAN_IDLE;
                end else begin
                    d.idx  = q.idx + 4'h1;
                    d.scan = cam_pkg::SCAN_READ;
                end
            end
            default: d.scan = cam_pkg::SCAN_IDLE;
        endcase

        d.arReady = !d.rPend && !d.rValid && (d.scan != cam_pkg::SCAN_READ);
        d.irq     = |(d.irqStat & d.irqEn);

        if (rst) begin
            d          = '0;
            d.awReady  = 1'b1;
            d.wReady   = 1'b1;
            d.arReady  = 1'b1;
            d.camCount = `CAM_RST_COUNT;
            d.source   = cam_pkg::pos_source_t'(`CAM_RST_SOURCE);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        q <= d;
    end

    // Outputs straight from state
    assign axiRsp.awready = q.awReady;
    assign axiRsp.wready  = q.wReady;
    assign axiRsp.bvalid  = q.bValid;
    assign axiRsp.bresp   = q.bResp;
    assign axiRsp.arready = q.arReady;
    assign axiRsp.rvalid  = q.rValid;
    assign axiRsp.rdata   = q.rData;
    assign axiRsp.rresp   = q.rResp;
    assign camSwitchFlag  = q.switchFlags;
    assign plcFlag        = q.plcFlags;
    assign camActive      = q.active;
    assign irq            = q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Checks on the scanner, flags, cycle position, interrupt and read channel
    idle_when_zero_a: assert property ((q.scan == cam_pkg::SCAN_IDLE && q.camCount == 4'h0)
        |=> q.scan == cam_pkg::SCAN_IDLE) else $error("scan started with zero count");
    scan_bound_a: assert property (q.scan != cam_pkg::SCAN_IDLE |-> q.idx < q.scanCount)
        else $error("cam index beyond count");
    scan_sequence_a: assert property ((q.scan == cam_pkg::SCAN_IDLE && tickHit && q.camCount != 4'h0)
        |=> q.scan == cam_pkg::SCAN_READ ##1 q.scan == cam_pkg::SCAN_EVAL) else $error("scan did not start");
    switch_set_a: assert property (evalEnter
        |=> (q.switchFlags & $past(actSwitch)) == $past(actSwitch)) else $error("switch flags not set");
    flag_clear_a: assert property (evalLeave
        |=> (q.switchFlags & $past(actSwitch)) == 16'h0 && !q.plcFlags[$past(actFlagA)])
        else $error("flags not cleared");
    plc_set_a: assert property (evalEnter |=> q.plcFlags[$past(actFlagA)] && q.plcFlags[$past(actFlagB)])
        else $error("logic flags not set");
    entry_latch_a: assert property (evalEnter |=> q.entryPos[$past(q.idx)] == $past(q.scanPos))
        else $error("entry position not latched");
    hyst_hold_a: assert property ((q.scan == cam_pkg::SCAN_EVAL && q.active[q.idx] && !camInside
        && camDist <= q.hyst) |=> q.active[$past(q.idx)]) else $error("cam left inside hysteresis");
    actual_src_a: assert property ((tickHit && q.source == cam_pkg::SOURCE_ACTUAL_POSITION)
        |=> q.cycPos == $past(actualPosition)) else $error("actual position not followed");
    cycle_wrap_a: assert property ((tickHit && q.source != cam_pkg::SOURCE_ACTUAL_POSITION && q.cycleLen != 32'h0
        && !cycAcc[31] && cycAcc >= q.cycleLen) |=> q.cycPos == $past(cycAcc) - $past(q.cycleLen))
        else $error("cycle did not wrap");
    irq_event_a: assert property ((evalEnter && q.irqEn[q.idx]) |=> q.irqStat[$past(q.idx)] && q.irq)
        else $error("entry did not raise interrupt");
    rvalid_hold_a: assert property ((q.rValid && !axiReq.rready) |=> q.rValid && $stable(q.rData))
        else $error("read data dropped");

endmodule : electronic_cam_controller
`default_nettype wire

// file: rtl/cam_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the cam controller
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz clock
// Notes:   Cam table words sit at base 0x100 + cam*16 + word*4
// Behaviour
// - Sixteen cams, each with start and end
// - Each cam owns an action register
// - Active cam sets its selected switch flags
// - Switch flags leave the block as outputs
// - Active cam also sets two logic flags
// - Zero cam count keeps the scanner idle
// - Positions 0..2147483647, reset zero, unchecked
// - Action word 32 bits, resets to ffff0000
// - Position wraps to zero past cycle length
// - Cycle length ignored for actual position source
// - Units: 65536 per revolution or user units
// - Source codes: 0 encoder, 1 reference, 2 actual
// - Only the configured count is evaluated, 0..15
// - Entry position latched; leave needs hysteresis
`ifndef CAM_CONSTS_SVH
`define CAM_CONSTS_SVH

`define CAM_NUM_CAMS       16
`define CAM_CLK_NS         10
`define CAM_TICK_NS        1000000

`define CAM_OFF_CTRL       12'h000
`define CAM_OFF_CYCLE      12'h004
`define CAM_OFF_HYST       12'h008
`define CAM_OFF_ACTIVE     12'h00c
`define CAM_OFF_SWITCH     12'h010
`define CAM_OFF_IRQ_STAT   12'h014
`define CAM_OFF_IRQ_CLR    12'h018
`define CAM_OFF_IRQ_EN     12'h01c
`define CAM_OFF_POS        12'h020
`define CAM_TABLE_PAGE     4'h1

`define CAM_WORD_START     2'h0
`define CAM_WORD_END       2'h1
`define CAM_WORD_ACTION    2'h2

`define CAM_CTRL_COUNT_LSB 0
`define CAM_CTRL_SRC_LSB   8
`define CAM_ACT_FLAGA_LSB  16
`define CAM_ACT_FLAGB_LSB  24

`define CAM_RST_ACTION     32'hffff0000
`define CAM_RST_POS        32'h00000000
`define CAM_RST_COUNT      4'h0
`define CAM_RST_SOURCE     2'h2
`define CAM_POS_MASK       32'h7fffffff

`define CAM_RESP_OKAY      2'h0
`define CAM_RESP_SLVERR    2'h2

`endif

// file: rtl/cam_pkg.sv
// Purpose: Types shared by the cam controller and its table memory
// Assumes: Constants live in cam_consts.svh
// Notes:   Bus structs keep the published AXI signal names
package cam_pkg;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_READ = 2'b01,
        SCAN_EVAL = 2'b11
    } scan_state_t;

    typedef enum logic [1:0] {
        SOURCE_POSITION_ENCODER  = 2'h0,
        SOURCE_REFERENCE_ENCODER = 2'h1,
        SOURCE_ACTUAL_POSITION   = 2'h2
    } pos_source_t;

    typedef struct packed {
        logic [31:0] action;
        logic [31:0] endPos;
        logic [31:0] startPos;
    } cam_entry_t;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic        wrEn;
        logic [3:0]  wrIdx;
        logic [1:0]  wrWord;
        logic [31:0] wrData;
        logic [3:0]  wrStrb;
        logic [3:0]  rdIdx;
    } mem_req_t;

endpackage : cam_pkg

// file: rtl/cam_table_mem.sv
// Purpose: Cam table storage, one entry of start, end and action per cam
// Assumes: Word 3 of an entry does not exist and ignores writes
// Notes:   Read data come from a register one edge after the index
`include "cam_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module cam_table_mem #(
    parameter int Depth = `CAM_NUM_CAMS
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire cam_pkg::mem_req_t memReq,
    output cam_pkg::cam_entry_t    rdEntry
);

    typedef struct packed {
        cam_pkg::cam_entry_t [Depth-1:0] entries;
        cam_pkg::cam_entry_t             rdData;
    } mem_state_t;

    mem_state_t q;
    mem_state_t d;

    // Byte-wise write, registered read, reset to defaults
    always_comb begin
        d = q;
        if (memReq.wrEn && memReq.wrWord != 2'h3) begin
            for (int b = 0; b < 4; b++) begin
                if (memReq.wrStrb[b]) begin
                    d.entries[memReq.wrIdx][memReq.wrWord * 32 + b * 8 +: 8] = memReq.wrData[b * 8 +: 8];
                end
            end
        end
        d.rdData = q.entries[memReq.rdIdx];
        if (rst) begin
            for (int i = 0; i < Depth; i++) begin
                d.entries[i].startPos = `CAM_RST_POS;
                d.entries[i].endPos   = `CAM_RST_POS;
                d.entries[i].action   = `CAM_RST_ACTION;
            end
            d.rdData = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        q <= d;
    end

    assign rdEntry = q.rdData;

endmodule : cam_table_mem
`default_nettype wire

// file: verif/position_source_model.sv
// Purpose: Position sources that feed the cam controller
// Assumes: Bench sets one target position on clk
// Notes:   Reference and actual sources carry fixed offsets
`timescale 1ns/1ns
`default_nettype none
module position_source_model (
    input  wire logic        clk,
    input  wire logic [30:0] target,
    output logic [31:0]      encPos,
    output logic [31:0]      refPos,
    output logic [31:0]      actPos
);
    // Encoder position kept in range
    // Registered sources, bit 31 clear unless an offset carries into it
    always_ff @(posedge clk) begin
        encPos <= {1'b0, target};
        refPos <= {1'b0, target} + 32'h00000032;
        actPos <= {1'b0, target} + 32'h000007d0;
    end
endmodule : position_source_model
`default_nettype wire

// file: verif/electronic_cam_controller_tb.sv
// Purpose: Register and cam behaviour checks of the cam controller
// Assumes: TickCycles of 20, so 50 cycles cover two full scans
// Notes:   Ready signals of the responses are held high throughout
`include "cam_consts.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin fails++; $display("BAD t=%0t %h %h", $time, a, e); end end
module electronic_cam_controller_tb;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    cam_pkg::axi_req_t req = '0;
    cam_pkg::axi_rsp_t rsp;
    logic [30:0]       target = '0;
    logic [31:0]       encPos, refPos, actPos, rdData;
    logic [1:0]        rdResp, wrResp;
    logic [15:0]       sw, act;
    logic [255:0]      plc;
    logic              irq;
    logic [31:0]       srcExp [3] = '{32'd100, 32'd150, 32'd2100};
    int                fails = 0;
    int                samplesChecked = 0;

    // Free running 100 MHz clock
    always #5 clk = ~clk;

    position_source_model src (.clk(clk), .target(target), .encPos(encPos), .refPos(refPos), .actPos(actPos));
    electronic_cam_controller #(.NumCams(16), .TickCycles(20)) DUT (.clk(clk), .rst(rst), .axiReq(req),
        .axiRsp(rsp), .positionEncoderPos(encPos), .referenceEncoderPos(refPos), .actualPosition(actPos),
        .camSwitchFlag(sw), .plcFlag(plc), .camActive(act), .irq(irq));

    // Write one word; address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        do begin
            @(posedge clk);
            n++;
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 200);
        wrResp = rsp.bresp;
        if (n >= 200) fails++;
    endtask : wr

    // Read one word; data taken at the answer edge
    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do begin
            @(posedge clk);
            n++;
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 200);
        rdData = rsp.rdata;
        rdResp = rsp.rresp;
        if (n >= 200) fails++;
    endtask : rd

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        `CHK(rdData, e)
    endtask : rchk

    // Move the source and let two scans pass
    task automatic move(input logic [30:0] p);
        target <= p;
        repeat (50) @(posedge clk);
    endtask : move

    task automatic finish_test();
        if (fails == 0 && samplesChecked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // Hang guard
    initial begin
        #100000;
        fails++;
        finish_test();
    end

    // Main sequence
    initial begin
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        req.rready <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(`CAM_OFF_CTRL, 32'h00000200);
        rchk(`CAM_OFF_CYCLE, 32'h0);
        rchk(12'h100, 32'h0);
        rchk(12'h104, 32'h0);
        rchk(12'h108, `CAM_RST_ACTION);
        rd(12'h030);
        `CHK({rdResp, rdData}, {`CAM_RESP_SLVERR, 32'h0})
        wr(12'h030, 32'h1);
        `CHK(wrResp, `CAM_RESP_SLVERR)
        wr(12'h100, 32'd100);
        wr(12'h104, 32'd200);
        wr(12'h108, 32'h07050009);
        rchk(12'h108, 32'h07050009);
        wr(`CAM_OFF_CYCLE, 32'd1000);
        `CHK(wrResp, `CAM_RESP_OKAY)
        wr(`CAM_OFF_CTRL, 32'h0);
        move(31'd150);
        `CHK(act, 16'h0)
        wr(`CAM_OFF_CTRL, 32'h1);
        move(31'd150);
        `CHK(act, 16'h1)
        `CHK(sw, 16'h0009)
        `CHK({plc[7], plc[5]}, 2'b11)
        rchk(`CAM_OFF_IRQ_STAT, 32'h1);
        `CHK(irq, 1'b0)
        wr(`CAM_OFF_IRQ_EN, 32'h1);
        move(31'd150);
        `CHK(irq, 1'b1)
        wr(`CAM_OFF_IRQ_CLR, 32'h1);
        move(31'd150);
        `CHK(irq, 1'b0)
        move(31'd300);
        `CHK({act, sw, plc}, 288'h0)
        wr(`CAM_OFF_HYST, 32'd100);
        move(31'd150);
        move(31'd210);
        `CHK(act, 16'h1)
        move(31'd260);
        `CHK(act, 16'h0)
        move(31'd1150);
        rchk(`CAM_OFF_POS, 32'd150);
        `CHK(act, 16'h1)
        // Cam 1 with a wrapped window, outside the count first
        wr(12'h110, 32'd900);
        wr(12'h114, 32'd300);
        move(31'd150);
        `CHK(act, 16'h1)
        wr(`CAM_OFF_CTRL, 32'h2);
        move(31'd150);
        `CHK({act, plc[255]}, 17'h7)
        // Source code 3 is ignored, count still taken
        wr(`CAM_OFF_CTRL, 32'h301);
        rchk(`CAM_OFF_CTRL, 32'h1);
        // Single byte lane write
        req.wstrb <= 4'h1;
        wr(`CAM_OFF_HYST, 32'hffffff05);
        req.wstrb <= 4'hf;
        rchk(`CAM_OFF_HYST, 32'h5);
        for (int s = 0; s < 3; s++) begin
            wr(`CAM_OFF_CTRL, 32'h1 | (s << 8));
            move(31'd100);
            rchk(`CAM_OFF_POS, srcExp[s]);
        end
        finish_test();
    end
endmodule : electronic_cam_controller_tb
`default_nettype wire
